// ### verilog/common_tape_control.sv
// Common tape control: motion launch and delay timing, clocks, read routing, write path.
// What this block does
// (R1) Drive the direction line first, then raise the internal launch pulse.
// (R2) Each launch pulse becomes a transport command strobe plus preset gate.
// (R3) Transport places its coded delay preset on read lines while gated.
// (R4) Load the motion delay counter from the read lines under the gate.
// (R5) Count up after loading; at 2^14 drop the speed pending indication.
// (R6) The at-speed indication goes to formatter logic and the transport.
// (R7) At motion end raise speed pending and time another delay likewise.
// (R8) When the stop delay ends, drive the halt line so tape stops.
// (R9) Derive housekeeping clocks from the transport base clock.
// (R10) Route read characters to the PE path or NRZ path by mode.
// (R11) Add vertical parity to 8-bit write characters, making nine bits.
// (R12) Control when the longitudinal and cyclic check characters are written.
// (R13) Write multiplexer and buffer convert binary to phase-encoded form.
// (R14) Select all-zeros and all-ones for PE preamble and postamble.
// (R15) Transport supplies a continuous base clock while on-line.
// (R16) Speed pending asserted when accelerating or stopped, not during identification burst.
// (R17) Raise the longitudinal check strobe before the record pulse writing it.
// (R18) Inverted write buffer feeds back into the write multiplexer.
// (R19) Delay counter is 14 bits plus terminal flag, held until reload.
// (R20) Host initialize clears counter, raises speed pending, drives halt.
// (R21) Halt issued after the stop delay; speed pending stays until restart.
module common_tape_control import tape_ctl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic link_clk,
	input wire logic host_init,
	input wire logic func_load,
	input wire motion_func_type func_code,
	input wire logic motion_end,
	input wire logic identification_burst,
	input wire logic pe_mode,
	input wire logic write_mode,
	input wire wr_char_type wr_char,
	input wire logic record_end,
	input wire logic [1:0] pe_fill,
	input wire logic [8:0] cyclic_check_char,
	input wire logic [8:0] longitudinal_check_char,
	input wire logic [8:0] rd_pins,
	input wire logic wrt_clk_pin,
	output xport_ctl_type xport_r,
	output logic launch_r,
	output logic [8:0] wd,
	output logic record_pulse_r,
	output logic longitudinal_check_strobe_r,
	output logic wr_char_ready_r,
	output logic [8:0] pe_rd_r,
	output logic [8:0] nrz_rd_r,
	output logic [2:0] hk_clk_r
);

	// ****************************************
	// Link clock domain
	// ****************************************
	// Housekeeping clocks divided from the transport base clock. [R9]
	// Only a counter lives here, so nothing needs to finish with the clock.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			hk_clk_r <= HK_RST;
		end else begin
			hk_clk_r <= hk_clk_r + 3'h1; // [R9] [R15]
		end
	end

	// ****************************************
	// Synchronisers and edge events
	// ****************************************
	logic [8:0] rd_s;
	logic [1:0] ev_s;
	logic tick_d_r;
	logic wclk_d_r;
	logic tick_ev;
	logic wclk_ev;

	sync3 #(.W(9)) u_rd_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d(rd_pins),
		.q(rd_s)
	);

	// A slower divider bit is crossed so each level stays long enough to agree.
	sync3 #(.W(2)) u_ev_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d({hk_clk_r[TICK_BIT], wrt_clk_pin}),
		.q(ev_s)
	);

	// Previous values for edge detection on the settled levels.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_d_r <= 1'b0;
			wclk_d_r <= 1'b0;
		end else if (clk_en) begin
			tick_d_r <= ev_s[1];
			wclk_d_r <= ev_s[0];
		end
	end

	assign tick_ev = ev_s[1] ^ tick_d_r;
	assign wclk_ev = ev_s[0] & ~wclk_d_r;

	// ****************************************
	// Motion sequencer
	// ****************************************
	motion_state_type state_r;
	motion_state_type state_nxt;
	motion_func_type dir_r;
	motion_func_type dir_nxt;
	logic [2:0] wait_r;
	logic [2:0] wait_nxt;
	logic [14:0] cnt_r;
	logic load_now;
	logic dir_any;
	xport_ctl_type xport_nxt;

	// The preset is taken on the last gated cycle, after it has crossed in.
	assign load_now = (state_r == MV_LOAD || state_r == MV_STOPGATE) && wait_r == PRESET_HOLD_CYC - 3'h1;
	assign dir_any = xport_r.tape_ahead_cmd | xport_r.tape_backward_cmd | xport_r.tape_wind_back_cmd;

	// Next state of the motion sequence.
	always_comb begin
		state_nxt = state_r;
		dir_nxt = dir_r;
		wait_nxt = wait_r;
		case (state_r)
			MV_IDLE: begin
				if (func_load && func_code != FN_NONE) begin
					state_nxt = MV_DIR; // [R1]
					dir_nxt = func_code;
					wait_nxt = WAIT_RST;
				end
			end
			MV_DIR: begin
				wait_nxt = wait_r + 3'h1;
				if (wait_r == DIR_LEAD_CYC - 3'h1) begin
					state_nxt = MV_LAUNCH; // [R1]
				end
			end
			MV_LAUNCH: begin
				state_nxt = MV_LOAD; // [R2]
				wait_nxt = WAIT_RST;
			end
			MV_LOAD: begin
				wait_nxt = wait_r + 3'h1;
				if (load_now) begin
					state_nxt = MV_ACCEL;
				end
			end
			MV_ACCEL: begin
				if (cnt_r[CNT_TERM_BIT]) begin
					state_nxt = MV_RUN; // [R5]
				end
			end
			MV_RUN: begin
				if (motion_end) begin
					state_nxt = MV_STOPGATE; // [R7]
					wait_nxt = WAIT_RST;
				end
			end
			MV_STOPGATE: begin
				wait_nxt = wait_r + 3'h1;
				if (load_now) begin
					state_nxt = MV_DECEL; // [R7]
				end
			end
			MV_DECEL: begin
				if (cnt_r[CNT_TERM_BIT]) begin
					state_nxt = MV_IDLE; // [R21]
					dir_nxt = FN_NONE;
				end
			end
			default: begin
				state_nxt = MV_IDLE;
				dir_nxt = FN_NONE;
			end
		endcase
		if (host_init) begin
			state_nxt = MV_IDLE; // [R20]
			dir_nxt = FN_NONE;
			wait_nxt = WAIT_RST;
		end
	end

	// State, direction latch and wait counter.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= MV_IDLE;
			dir_r <= FN_NONE;
			wait_r <= WAIT_RST;
		end else if (clk_en) begin
			state_r <= state_nxt;
			dir_r <= dir_nxt;
			wait_r <= wait_nxt;
		end
	end

	// Motion delay counter: 14 bits and a terminal flag that sticks until reload.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= CNT_RST;
		end else if (clk_en) begin
			if (host_init) begin
				cnt_r <= CNT_RST; // [R20]
			end else if (load_now) begin
				cnt_r <= preset_count(rd_s); // [R3] [R4]
			end else if (tick_ev && !cnt_r[CNT_TERM_BIT] && (state_r == MV_ACCEL || state_r == MV_DECEL)) begin
				cnt_r <= cnt_r + 15'h0001; // [R5] [R7] [R19]
			end
		end
	end

	// Transport lines are decoded from the next state so they leave flip-flops.
	always_comb begin
		xport_nxt.tape_ahead_cmd = dir_nxt == FN_FWD; // [R1]
		xport_nxt.tape_backward_cmd = dir_nxt == FN_REV; // [R1]
		xport_nxt.tape_wind_back_cmd = dir_nxt == FN_TAPE_WIND_BACK_CMD; // [R1]
		xport_nxt.slave_set = state_nxt == MV_LAUNCH; // [R2]
		xport_nxt.delay_preset_gate = state_nxt == MV_LAUNCH || state_nxt == MV_LOAD
			|| state_nxt == MV_STOPGATE; // [R2] [R7]
		xport_nxt.halt_motion = state_nxt == MV_IDLE; // [R8] [R20] [R21]
		// The burst overrides because the transport must see full speed then.
		xport_nxt.speed_pending = state_nxt != MV_RUN && !identification_burst; // [R5] [R6] [R16]
	end

	// Registered transport lines and internal launch pulse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xport_r <= '{halt_motion: 1'b1, speed_pending: 1'b1, default: 1'b0};
			launch_r <= 1'b0;
		end else if (clk_en) begin
			xport_r <= xport_nxt; // [R6]
			launch_r <= state_nxt == MV_LAUNCH; // [R1]
		end
	end

	// ****************************************
	// Read routing
	// ****************************************
	// Preset cycles are kept off both paths since they carry no tape data.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pe_rd_r <= CHAR_ZERO;
			nrz_rd_r <= CHAR_ZERO;
		end else if (clk_en) begin
			if (!write_mode && !xport_r.delay_preset_gate) begin
				pe_rd_r <= pe_mode ? rd_s : CHAR_ZERO; // [R10]
				nrz_rd_r <= pe_mode ? CHAR_ZERO : rd_s; // [R10]
			end else begin
				pe_rd_r <= CHAR_ZERO;
				nrz_rd_r <= CHAR_ZERO;
			end
		end
	end

	// ****************************************
	// Write path
	// ****************************************
	end_seq_type eq_r;
	end_seq_type eq_nxt;
	wr_sel_type sel;
	logic have_char;
	logic wr_load;
	logic record_pulse;
	logic taken;

	// Fill patterns win over check characters, which win over data.
	always_comb begin
		if (pe_fill == FILL_ZERO) begin
			sel = WS_ZERO; // [R14]
		end else if (pe_fill == FILL_ONE) begin
			sel = WS_ONE; // [R14]
		end else if (eq_r == EQ_CRC) begin
			sel = WS_CRC; // [R12]
		end else if (eq_r == EQ_LRC) begin
			sel = WS_LRC; // [R12]
		end else begin
			sel = WS_DATA;
		end
	end

	assign have_char = sel != WS_DATA || wr_char.valid;
	assign wr_load = wclk_ev && write_mode;

	// End of record in NRZ: the cyclic check goes first, then the longitudinal.
	always_comb begin
		eq_nxt = eq_r;
		case (eq_r)
			EQ_IDLE: begin
				if (record_end && write_mode && !pe_mode) begin
					eq_nxt = EQ_CRC; // [R12]
				end
			end
			EQ_CRC: begin
				if (taken && sel == WS_CRC) begin
					eq_nxt = EQ_LRC; // [R12]
				end
			end
			EQ_LRC: begin
				if (taken && sel == WS_LRC) begin
					eq_nxt = EQ_IDLE; // [R12]
				end
			end
			default: eq_nxt = EQ_IDLE;
		endcase
		if (host_init) begin
			eq_nxt = EQ_IDLE;
		end
	end

	write_mux_buf u_wr (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(wr_load),
		.pe_mode(pe_mode),
		.sel(sel),
		.have_char(have_char),
		.char_in(wr_char.data),
		.crc_char(cyclic_check_char),
		.lrc_char(longitudinal_check_char),
		.buf_r(wd),
		.half_r(),
		.record_pulse(record_pulse),
		.taken(taken)
	);

	// Record pulse, strobe and character acknowledge line up with the buffer.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eq_r <= EQ_IDLE;
			record_pulse_r <= 1'b0;
			longitudinal_check_strobe_r <= 1'b0;
			wr_char_ready_r <= 1'b0;
		end else if (clk_en) begin
			eq_r <= eq_nxt;
			record_pulse_r <= record_pulse; // [R13]
			longitudinal_check_strobe_r <= eq_nxt == EQ_LRC; // [R17]
			wr_char_ready_r <= taken && sel == WS_DATA; // [R11]
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !clk_en);

	sequence launch_seq;
		xport_r.slave_set && xport_r.delay_preset_gate && launch_r;
	endsequence

	sequence gate_hold_seq;
		!xport_r.slave_set && xport_r.delay_preset_gate;
	endsequence

	chk_dir_lead: assert property ($rose(xport_r.slave_set) |-> dir_any && $past(dir_any, 4)) // [R1]
		else $error("launch came without direction lead");
	chk_launch_gate: assert property ($rose(launch_r) |-> launch_seq ##1 gate_hold_seq[*5]) // [R2]
		else $error("launch did not give strobe and preset gate");
	chk_preset_load: assert property ($fell(xport_r.delay_preset_gate) && !$past(host_init) |-> // [R4]
		cnt_r == preset_count($past(rd_s)))
		else $error("delay counter not loaded from preset");
	chk_speed_reached: assert property ((state_r == MV_ACCEL && cnt_r[CNT_TERM_BIT] && !host_init) |=> // [R5]
		!xport_r.speed_pending && !xport_r.halt_motion)
		else $error("speed pending stayed after terminal count");
	chk_terminal_hold: assert property ((cnt_r[CNT_TERM_BIT] && !load_now && !host_init) |=> // [R19]
		cnt_r == $past(cnt_r))
		else $error("terminal count not held");
	chk_end_decel: assert property ((state_r == MV_RUN && motion_end && !host_init) |=> // [R7]
		gate_hold_seq and (xport_r.speed_pending || $past(identification_burst)))
		else $error("motion end did not start stop delay");
	chk_halt_end: assert property ((state_r == MV_DECEL && cnt_r[CNT_TERM_BIT]) |=> // [R8]
		xport_r.halt_motion && !dir_any && xport_r.speed_pending != $past(identification_burst))
		else $error("halt not driven after stop delay");
	chk_no_early_halt: assert property ((state_r == MV_DECEL && !cnt_r[CNT_TERM_BIT] && !host_init) |=> // [R21]
		!xport_r.halt_motion)
		else $error("halt before stop delay ended");
	chk_init_clear: assert property ((host_init && !identification_burst) |=> // [R20]
		xport_r.halt_motion && xport_r.speed_pending && cnt_r == CNT_RST)
		else $error("initialize did not clear motion");
	chk_burst_speed: assert property (identification_burst |=> !xport_r.speed_pending) // [R16]
		else $error("speed pending during identification burst");
	chk_read_route: assert property ((!write_mode && !xport_r.delay_preset_gate && pe_mode) |=> // [R10]
		pe_rd_r == $past(rd_s) && nrz_rd_r == CHAR_ZERO)
		else $error("PE read character misrouted");
	chk_lrc_strobe: assert property ($fell(longitudinal_check_strobe_r) && !$past(host_init) |-> // [R17]
		record_pulse_r)
		else $error("check strobe did not precede record pulse");

endmodule

// ### include/tape_ctl_pkg.sv
// Shared constants, types and helpers for the common tape control block.
package tape_ctl_pkg;

	// ****************************************
	// Counts, positions and values after reset
	// ****************************************
	localparam logic [14:0] CNT_RST = 15'h0000;
	localparam int CNT_TERM_BIT = 14;
	localparam int PRESET_LSB = 6;
	localparam logic [2:0] DIR_LEAD_CYC = 3'h4;
	localparam logic [2:0] PRESET_HOLD_CYC = 3'h6;
	localparam logic [2:0] WAIT_RST = 3'h0;
	localparam logic [2:0] HK_RST = 3'h0;
	localparam int TICK_BIT = 1;
	localparam logic [8:0] CHAR_ZERO = 9'h000;
	localparam logic [8:0] CHAR_ONE = 9'h1FF;
	localparam logic [1:0] FILL_ZERO = 2'h1;
	localparam logic [1:0] FILL_ONE = 2'h2;

	// ****************************************
	// Enumerations and carriers
	// ****************************************
	typedef enum logic [2:0] {
		MV_IDLE = 3'b000,
		MV_DIR = 3'b001,
		MV_LAUNCH = 3'b010,
		MV_LOAD = 3'b011,
		MV_ACCEL = 3'b100,
		MV_RUN = 3'b101,
		MV_STOPGATE = 3'b110,
		MV_DECEL = 3'b111
	} motion_state_type;

	typedef enum logic [1:0] {
		FN_NONE = 2'b00,
		FN_FWD = 2'b01,
		FN_REV = 2'b10,
		FN_TAPE_WIND_BACK_CMD = 2'b11
	} motion_func_type;

	typedef enum logic [2:0] {
		WS_DATA = 3'b000,
		WS_CRC = 3'b001,
		WS_LRC = 3'b010,
		WS_ZERO = 3'b011,
		WS_ONE = 3'b100
	} wr_sel_type;

	typedef enum logic [1:0] {
		EQ_IDLE = 2'b00,
		EQ_CRC = 2'b01,
		EQ_LRC = 2'b10
	} end_seq_type;

	typedef struct packed {
		logic tape_ahead_cmd;
		logic tape_backward_cmd;
		logic tape_wind_back_cmd;
		logic slave_set;
		logic delay_preset_gate;
		logic halt_motion;
		logic speed_pending;
	} xport_ctl_type;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} wr_char_type;

	// ****************************************
	// Helpers
	// ****************************************
	// Odd vertical parity over one data character.
	function automatic logic odd_par(input logic [7:0] d);
		return ~^d;
	endfunction

	// Places the coded preset from the read lines into the delay counter.
	function automatic logic [14:0] preset_count(input logic [8:0] rd);
		return {1'b0, rd[7:0], 6'h00};
	endfunction

endpackage

// ### verilog/sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module sync3 import tape_ctl_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// Stage one feeds stage two only; a bit moves once the later stages agree.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q <= '0;
		end else if (clk_en) begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q <= (s2_r & s3_r) | (q & (s2_r | s3_r));
		end
	end

endmodule

// ### verilog/write_mux_buf.sv
// Write multiplexer and write buffer with parity and phase-encoding conversion.
module write_mux_buf import tape_ctl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic load,
	input wire logic pe_mode,
	input wire wr_sel_type sel,
	input wire logic have_char,
	input wire logic [7:0] char_in,
	input wire logic [8:0] crc_char,
	input wire logic [8:0] lrc_char,
	output logic [8:0] buf_r,
	output logic half_r,
	output logic record_pulse,
	output logic taken
);

	logic second;
	logic [8:0] mux_val;

	// The second half of a phase-encoded cell is the inverted buffer.
	assign second = pe_mode & half_r;
	assign record_pulse = load & (second | have_char);
	assign taken = load & have_char & ~second;

	// Source selection: data with parity, check characters or fill patterns.
	always_comb begin
		case (sel)
			WS_DATA: mux_val = {odd_par(char_in), char_in}; // [R11]
			WS_CRC: mux_val = crc_char; // [R12]
			WS_LRC: mux_val = lrc_char; // [R12]
			WS_ZERO: mux_val = CHAR_ZERO; // [R14]
			WS_ONE: mux_val = CHAR_ONE; // [R14]
			default: mux_val = CHAR_ZERO;
		endcase
	end

	// Each record event loads a fresh character or, in PE, its complement.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_r <= CHAR_ZERO;
			half_r <= 1'b0;
		end else if (clk_en && load) begin
			if (second) begin
				buf_r <= ~buf_r; // [R13] [R18]
				half_r <= 1'b0;
			end else if (have_char) begin
				buf_r <= mux_val;
				half_r <= pe_mode; // [R13]
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !clk_en);

	chk_data_parity: assert property ((taken && sel == WS_DATA) |=> // [R11]
		buf_r == {odd_par($past(char_in)), $past(char_in)})
		else $error("write character parity wrong");
	chk_pe_invert: assert property ((load && second) |=> buf_r == ~$past(buf_r) && !half_r) // [R18]
		else $error("second half cell is not the inverted buffer");
	chk_fill_ones: assert property ((taken && sel == WS_ONE) |=> buf_r == CHAR_ONE) // [R14]
		else $error("all-ones fill not written");

endmodule

// ### dv/tape_transport_model.sv
// Behavioural tape transport: base clock, write clock, read lines and delay preset.
module tape_transport_model import tape_ctl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire xport_ctl_type xport,
	input wire logic write_on,
	input wire logic [8:0] read_char,
	output logic link_clk,
	output logic [8:0] rd_pins,
	output logic wrt_clk_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [8:0] PRESET = 9'h0FF;
	localparam int WCLK_HALF = 20;
	logic [1:0] hold_r;
	int wcnt_r;

	// ****************************************
	// Clocks and read lines
	// ****************************************
	// The base clock runs free while on-line, phase unrelated to clk.
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end

	// Preset stays a little past the gate so the synchroniser sees it settle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 2'h0;
		end else if (xport.delay_preset_gate) begin
			hold_r <= 2'h2;
		end else if (hold_r != 2'h0) begin
			hold_r <= hold_r - 2'h1;
		end
	end
	assign rd_pins = (xport.delay_preset_gate || hold_r != 2'h0) ? PRESET : read_char;

	// Write clock only runs at speed; otherwise it stands low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n || !write_on || xport.speed_pending) begin
			wcnt_r <= 0;
			wrt_clk_pin <= 1'b0;
		end else if (wcnt_r == WCLK_HALF - 1) begin
			wcnt_r <= 0;
			wrt_clk_pin <= ~wrt_clk_pin;
		end else begin
			wcnt_r <= wcnt_r + 1;
		end
	end
endmodule

// ### dv/common_tape_control_tb_top.sv
// Self-checking bench for the common tape control block.
module common_tape_control_tb_top import tape_ctl_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, host_init = 1'b0, func_load = 1'b0;
	logic motion_end = 1'b0, identification_burst = 1'b0, pe_mode = 1'b0, write_mode = 1'b0;
	logic record_end = 1'b0, write_on = 1'b0, link_clk, wrt_clk_pin, record_pulse_r, launch_r;
	logic longitudinal_check_strobe_r, wr_char_ready_r;
	logic [1:0] pe_fill = 2'h0;
	logic [2:0] hk_clk_r;
	logic [8:0] read_char = 9'h1A5, rd_pins, wd, pe_rd_r, nrz_rd_r;
	motion_func_type func_code = FN_NONE;
	wr_char_type wr_char = '0;
	xport_ctl_type xport_r;
	int err_total = 0, total_checks = 0;
	wire [2:0] dirs = {xport_r.tape_ahead_cmd, xport_r.tape_backward_cmd, xport_r.tape_wind_back_cmd};

	// ****************************************
	// Clock, design and partner
	// ****************************************
	// The 40 MHz system clock.
	always #12.5 clk = ~clk;

	common_tape_control dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .link_clk(link_clk),
		.host_init(host_init), .func_load(func_load), .func_code(func_code), .motion_end(motion_end),
		.identification_burst(identification_burst), .pe_mode(pe_mode), .write_mode(write_mode),
		.wr_char(wr_char), .record_end(record_end), .pe_fill(pe_fill), .cyclic_check_char(9'h1C3),
		.longitudinal_check_char(9'h03C), .rd_pins(rd_pins), .wrt_clk_pin(wrt_clk_pin),
		.xport_r(xport_r), .launch_r(launch_r), .wd(wd), .record_pulse_r(record_pulse_r),
		.longitudinal_check_strobe_r(longitudinal_check_strobe_r), .wr_char_ready_r(wr_char_ready_r),
		.pe_rd_r(pe_rd_r), .nrz_rd_r(nrz_rd_r), .hk_clk_r(hk_clk_r));

	tape_transport_model xport_model (.clk(clk), .rst_n(rst_n), .xport(xport_r), .write_on(write_on),
		.read_char(read_char), .link_clk(link_clk), .rd_pins(rd_pins), .wrt_clk_pin(wrt_clk_pin));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("BAD at %0t: %s", $time, msg);
		end
	endtask

	// Counts falling edges until the flag reaches the wanted level, within a bound.
	task automatic wait_lvl(input int which, input logic lvl, input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((which == 0 ? xport_r.slave_set : which == 1 ? xport_r.speed_pending :
			which == 2 ? xport_r.halt_motion : record_pulse_r) !== lvl && n < lim);
	endtask

	task automatic start_motion(input motion_func_type f);
		int nd, ns, n;
		func_code = f;
		func_load = 1'b1;
		@(negedge clk);
		func_load = 1'b0;
		wait_lvl(0, 1'b1, 20, ns);
		check(launch_r === 1'b1 && xport_r.delay_preset_gate === 1'b1, "launch");
		check(dirs === (f == FN_FWD ? 3'h4 : f == FN_REV ? 3'h2 : 3'h1), "direction");
		// The preset gate must stay up, with the strobe low, for the next five cycles.
		nd = 0;
		repeat (5) begin
			@(negedge clk);
			nd += (xport_r.delay_preset_gate === 1'b1);
			check(xport_r.slave_set === 1'b0, "strobe width");
		end
		wait_lvl(1, 1'b0, 420, n);
		check(nd == 5 && n >= 300 && n <= 360, "accel length");
		check(xport_r.halt_motion === 1'b0, "halt at speed");
	endtask

	task automatic stop_motion();
		int n;
		motion_end = 1'b1;
		@(negedge clk);
		motion_end = 1'b0;
		check(xport_r.speed_pending === 1'b1 && xport_r.delay_preset_gate === 1'b1, "stop delay");
		wait_lvl(2, 1'b1, 420, n);
		check(n >= 300 && n <= 360 && dirs === 3'h0, "halt timing");
		check(xport_r.speed_pending === 1'b1 && xport_r.slave_set === 1'b0, "stopped");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_motion();
		int n;
		motion_func_type fns[3] = '{FN_FWD, FN_REV, FN_TAPE_WIND_BACK_CMD};
		foreach (fns[i]) begin
			start_motion(fns[i]);
			func_code = FN_REV;
			func_load = 1'b1;
			@(negedge clk);
			func_load = 1'b0;
			wait_lvl(0, 1'b1, 10, n);
			// The refused load must leave the running direction untouched.
			check(n == 10 && dirs === 3'h4 >> i, "refused load");
			stop_motion();
		end
		$display("motion test done");
	endtask

	task automatic t_init_idb();
		int n;
		check(xport_r.halt_motion === 1'b1 && xport_r.speed_pending === 1'b1 && dirs === 3'h0, "reset");
		identification_burst = 1'b1;
		repeat (2) @(negedge clk);
		check(xport_r.speed_pending === 1'b0, "burst");
		identification_burst = 1'b0;
		func_code = FN_FWD;
		func_load = 1'b1;
		@(negedge clk);
		func_load = 1'b0;
		repeat (60) @(negedge clk);
		host_init = 1'b1;
		@(negedge clk);
		host_init = 1'b0;
		@(negedge clk);
		check(xport_r.halt_motion === 1'b1 && dirs === 3'h0 && xport_r.speed_pending === 1'b1, "init");
		wait_lvl(1, 1'b0, 400, n);
		check(n == 400, "init holds idle");
		$display("init test done");
	endtask

	task automatic t_read_hk();
		logic [2:0] p;
		int c[3];
		pe_mode = 1'b1;
		repeat (8) @(negedge clk);
		check(pe_rd_r === 9'h1A5 && nrz_rd_r === 9'h000, "pe read");
		pe_mode = 1'b0;
		repeat (8) @(negedge clk);
		check(nrz_rd_r === 9'h1A5 && pe_rd_r === 9'h000, "nrz read");
		c = '{0, 0, 0};
		@(negedge link_clk);
		p = hk_clk_r;
		repeat (16) begin
			@(negedge link_clk);
			for (int b = 0; b < 3; b++) c[b] += (hk_clk_r[b] !== p[b]);
			p = hk_clk_r;
		end
		check(c[0] == 16 && c[1] == 8 && c[2] == 4, "divided clocks");
		$display("read test done");
	endtask

	task automatic wr(input logic [7:0] d);
		int n;
		wr_char = '{data: d, valid: 1'b1};
		wait_lvl(3, 1'b1, 200, n);
		check(wd === {~^d, d} && wr_char_ready_r === 1'b1, "data char");
		wr_char.valid = 1'b0;
		// Let one edge pass so a following call never re-raises valid in the same step.
		@(negedge clk);
	endtask

	task automatic t_write();
		int n;
		logic [1:0] fills[2] = '{FILL_ZERO, FILL_ONE};
		write_mode = 1'b1;
		write_on = 1'b1;
		start_motion(FN_FWD);
		wr(8'h3C);
		wr(8'h01);
		record_end = 1'b1;
		@(negedge clk);
		record_end = 1'b0;
		wait_lvl(3, 1'b1, 200, n);
		check(wd === 9'h1C3, "cyclic char");
		@(negedge clk);
		check(longitudinal_check_strobe_r === 1'b1, "strobe before");
		wait_lvl(3, 1'b1, 200, n);
		check(wd === 9'h03C, "longitudinal char");
		pe_mode = 1'b1;
		wr(8'h5A);
		wait_lvl(3, 1'b1, 200, n);
		check(wd === ~{~^8'h5A, 8'h5A}, "phase half");
		// In PE each fill character takes two record events: the pattern, then its complement.
		foreach (fills[i]) begin
			pe_fill = fills[i];
			wait_lvl(3, 1'b1, 200, n);
			check(wd === (i == 0 ? CHAR_ZERO : CHAR_ONE), "fill");
			wait_lvl(3, 1'b1, 200, n);
			check(wd === (i == 0 ? CHAR_ONE : CHAR_ZERO), "fill half");
		end
		pe_fill = 2'h0;
		stop_motion();
		write_on = 1'b0;
		write_mode = 1'b0;
		$display("write test done");
	endtask

	// ****************************************
	// Run control
	// ****************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The whole run needs about 3700 cycles; the watchdog allows 20000, a little over five times that.
	initial begin
		#(20000 * 25);
		err_total++;
		$display("BAD at %0t: watchdog expired", $time);
		finish_test();
	end

	// Main sequence.
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		t_init_idb();
		t_read_hk();
		t_motion();
		t_write();
		finish_test();
	end
endmodule
